// *** logic/fpfh_pkg.sv ***
package fpfh_pkg;

  // clock
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;

  // times in their own units, counts derived
  localparam int SS_TIME_US = 4000;
  localparam int SS_CYC = SS_TIME_US * CLK_PER_US;
  localparam int FAULT_TIME_MS = 130;
  localparam int FAULT_CYC = (FAULT_TIME_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int JIT_PERIOD_US = 6000;
  localparam int JIT_CYC = JIT_PERIOD_US * CLK_PER_US;
  localparam int LATCH_FILT_NS = 13_000;
  localparam int LATCH_FILT_CYC = (LATCH_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // switching cycle
  localparam int PER_W = 12;
  localparam int NOM_PERIOD_CYC = 384;
  localparam int MAX_DUTY_PCT = 80;
  localparam int PCT_FULL = 100;
  localparam int JIT_PERMIL = 75;
  localparam int PERMIL_FULL = 1000;

  // levels in millivolts
  localparam int LVL_W = 12;
  localparam logic [LVL_W-1:0] LVL_FULL_MV = 12'h3e8;
  localparam logic [LVL_W-1:0] LVL_ZERO = 12'h000;
  localparam int FB_DIVISOR = 3;

  // compensation ramp, swing in microamps
  localparam int RAMP_W = 7;
  localparam logic [RAMP_W-1:0] RAMP_SWING_UA = 7'h64;
  localparam logic [RAMP_W-1:0] RAMP_ZERO = 7'h00;
  localparam int RAMP_RES_KOHM = 5;

  // hiccup
  localparam int HICCUP_W = 2;
  localparam logic [HICCUP_W-1:0] HICCUP_CYCLES = 2'h2;
  localparam logic [HICCUP_W-1:0] HICCUP_ZERO = 2'h0;

  typedef struct packed {
    logic below_off;
    logic below_latch;
    logic above_on;
    logic below_reset;
    logic fb_open;
    logic latch_high;
  } fpfh_cmp_t;

  localparam fpfh_cmp_t CMP_RESET = '{below_off: 1'b1, below_latch: 1'b1, above_on: 1'b0,
                                      below_reset: 1'b1, fb_open: 1'b0, latch_high: 1'b0};

  typedef struct packed {
    logic gate;
    logic startup_on;
    logic error;
    logic latched;
    logic running;
  } fpfh_status_t;

  typedef enum {ST_START, ST_RUN, ST_DECAY, ST_CHARGE} fpfh_state_t;

  function automatic logic [LVL_W-1:0] fpfh_div3(input logic [LVL_W-1:0] v);
    fpfh_div3 = LVL_W'(v / FB_DIVISOR);
  endfunction

  function automatic logic [LVL_W-1:0] fpfh_min(input logic [LVL_W-1:0] a, input logic [LVL_W-1:0] b);
    fpfh_min = (a < b) ? a : b;
  endfunction

endpackage

// *** logic/fpfh_soft_start.sv ***
`timescale 1ns/10ps
module fpfh_soft_start import fpfh_pkg::*; #(
  parameter int SS_CYCLES = SS_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic restart,
  output logic [LVL_W-1:0] ss_level
);
  localparam int STEP_CYC = (SS_CYCLES / int'(LVL_FULL_MV) > 0) ? SS_CYCLES / int'(LVL_FULL_MV) : 1;
  localparam logic [31:0] STEP_LAST = 32'(STEP_CYC - 1);

  logic [31:0] div_q, div_d;
  logic [LVL_W-1:0] lvl_q, lvl_d;

  // linear rise from zero to full, then hold
  always_comb begin
    div_d = div_q;
    lvl_d = lvl_q;
    if (restart) begin
      div_d = '0;
      lvl_d = LVL_ZERO;
    end else if (lvl_q < LVL_FULL_MV) begin
      if (div_q == STEP_LAST) begin
        div_d = '0;
        lvl_d = lvl_q + 1'b1;
      end else begin
        div_d = div_q + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
      lvl_q <= LVL_ZERO;
    end else begin
      div_q <= div_d;
      lvl_q <= lvl_d;
    end
  end

  assign ss_level = lvl_q;
endmodule // fpfh_soft_start

// *** logic/fpfh_osc_jitter.sv ***
`timescale 1ns/10ps
module fpfh_osc_jitter import fpfh_pkg::*; #(
  parameter int NOM_CYC = NOM_PERIOD_CYC,
  parameter int JIT_CYCLES = JIT_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  output logic cycle_start,
  output logic [PER_W-1:0] pos,
  output logic [PER_W-1:0] period
);
  localparam int DEV = (NOM_CYC * JIT_PERMIL) / PERMIL_FULL;
  localparam int STEPS = (DEV > 0) ? 4 * DEV : 1;
  localparam int STEP_CYC = (JIT_CYCLES / STEPS > 0) ? JIT_CYCLES / STEPS : 1;
  localparam logic [31:0] STEP_LAST = 32'(STEP_CYC - 1);
  localparam logic signed [PER_W:0] DEV_S = (PER_W+1)'(DEV);

  logic [31:0] jdiv_q, jdiv_d;
  logic signed [PER_W:0] off_q, off_d;
  logic up_q, up_d;
  logic [PER_W-1:0] pos_q, pos_d;
  logic [PER_W-1:0] per_q, per_d;
  logic start_q, start_d;

  // triangle sweep of the period between -dev and +dev
  always_comb begin
    jdiv_d = jdiv_q + 1'b1;
    off_d = off_q;
    up_d = up_q;
    if (jdiv_q == STEP_LAST) begin
      jdiv_d = '0;
      if (up_q) begin
        if (off_q >= DEV_S) up_d = 1'b0;
        else off_d = off_q + 1'sb1;
      end else begin
        if (off_q <= -DEV_S) up_d = 1'b1;
        else off_d = off_q - 1'sb1;
      end
    end
    start_d = (pos_q == per_q - 1'b1);
    pos_d = start_d ? '0 : pos_q + 1'b1;
    per_d = start_d ? PER_W'((PER_W+1)'(NOM_CYC) + off_q) : per_q;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      jdiv_q <= '0;
      off_q <= '0;
      up_q <= 1'b1;
      pos_q <= '0;
      per_q <= PER_W'(NOM_CYC);
      start_q <= 1'b0;
    end else begin
      jdiv_q <= jdiv_d;
      off_q <= off_d;
      up_q <= up_d;
      pos_q <= pos_d;
      per_q <= per_d;
      start_q <= start_d;
    end
  end

  assign cycle_start = start_q;
  assign pos = pos_q;
  assign period = per_q;
endmodule // fpfh_osc_jitter

// *** logic/fpfh_core.sv ***
`timescale 1ns/10ps
module fpfh_core import fpfh_pkg::*; #(
  parameter int NOM_CYC = NOM_PERIOD_CYC,
  parameter int SS_CYCLES = SS_CYC,
  parameter int FAULT_CYCLES = FAULT_CYC,
  parameter int JIT_CYCLES = JIT_CYC,
  parameter int RAMP_KOHM = RAMP_RES_KOHM
) (
  input wire logic mclk,
  input wire logic rst,
  input wire fpfh_cmp_t cmp_async,
  input wire logic [LVL_W-1:0] feedback_level,
  input wire logic [LVL_W-1:0] cs_level,
  output logic gate_drive,
  output logic startup_source_on,
  output logic [RAMP_W-1:0] ramp_current,
  output logic [LVL_W-1:0] modulation_level,
  output fpfh_status_t status
);
  localparam int RAMP_STEP_RAW = (NOM_CYC * MAX_DUTY_PCT) / (PCT_FULL * int'(RAMP_SWING_UA));
  localparam int RAMP_STEP_CYC = (RAMP_STEP_RAW > 0) ? RAMP_STEP_RAW : 1;
  localparam logic [7:0] RAMP_STEP_LAST = 8'(RAMP_STEP_CYC - 1);
  localparam logic [31:0] FAULT_LAST = 32'(FAULT_CYCLES - 1);
  localparam logic [15:0] LATCH_LAST = 16'(LATCH_FILT_CYC - 1);
  localparam int SUM_W = LVL_W + 2;
  localparam int DUTY_W = PER_W + 8;

  // two-stage synchroniser for every comparator result
  fpfh_cmp_t sync1_q, sync2_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_q <= CMP_RESET;
      sync2_q <= CMP_RESET;
    end else begin
      sync1_q <= cmp_async;
      sync2_q <= sync1_q;
    end
  end

  // switching clock with jitter
  logic cycle_start;
  logic [PER_W-1:0] pos;
  logic [PER_W-1:0] period;

  fpfh_osc_jitter #(
    .NOM_CYC(NOM_CYC),
    .JIT_CYCLES(JIT_CYCLES)
  ) u_osc (
    .mclk(mclk),
    .rst(rst),
    .cycle_start(cycle_start),
    .pos(pos),
    .period(period)
  );

  // soft-start ramp
  logic ss_restart;
  logic [LVL_W-1:0] ss_level;

  fpfh_soft_start #(
    .SS_CYCLES(SS_CYCLES)
  ) u_ss (
    .mclk(mclk),
    .rst(rst),
    .restart(ss_restart),
    .ss_level(ss_level)
  );

  // modulation level
  logic [LVL_W-1:0] fb_div3;
  logic [LVL_W-1:0] mod_raw;
  logic [LVL_W-1:0] mod_q, mod_d;

  always_comb begin
    fb_div3 = fpfh_div3(feedback_level);
    mod_raw = fpfh_min(ss_level, fb_div3);
    mod_d = fpfh_min(mod_raw, LVL_FULL_MV);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) mod_q <= LVL_ZERO;
    else mod_q <= mod_d;
  end

  // overload detection and fault timer
  logic overload;
  logic [31:0] ftmr_q, ftmr_d;
  logic err_q, err_d;
  logic fb_fault;
  logic run_q, run_d;

  always_comb begin
    overload = sync2_q.fb_open | (fb_div3 > LVL_FULL_MV);
    ftmr_d = ftmr_q;
    err_d = 1'b0;
    fb_fault = 1'b0;
    if (run_q && overload) begin
      err_d = 1'b1;
      if (ftmr_q == FAULT_LAST) fb_fault = 1'b1;
      else ftmr_d = ftmr_q + 1'b1;
    end else begin
      ftmr_d = '0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ftmr_q <= '0;
      err_q <= 1'b0;
    end else begin
      ftmr_q <= ftmr_d;
      err_q <= err_d;
    end
  end

  // latch input filter and latched shutdown
  logic [15:0] lfilt_q, lfilt_d;
  logic lat_q, lat_d;
  logic lat_trip;

  always_comb begin
    lfilt_d = '0;
    lat_trip = 1'b0;
    if (sync2_q.latch_high) begin
      if (lfilt_q == LATCH_LAST) begin
        lat_trip = 1'b1;
        lfilt_d = lfilt_q;
      end else begin
        lfilt_d = lfilt_q + 1'b1;
      end
    end
    lat_d = lat_q;
    if (lat_trip) lat_d = 1'b1;
    else if (sync2_q.below_reset) lat_d = 1'b0;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lfilt_q <= '0;
      lat_q <= 1'b0;
    end else begin
      lfilt_q <= lfilt_d;
      lat_q <= lat_d;
    end
  end

  // supply sequencing and double hiccup
  fpfh_state_t st_q, st_d;
  logic [HICCUP_W-1:0] hic_q, hic_d;
  logic src_q, src_d;
  logic fault_now;

  always_comb begin
    fault_now = sync2_q.below_off | fb_fault | lat_trip | lat_q;
    st_d = st_q;
    hic_d = hic_q;
    src_d = 1'b0;
    ss_restart = 1'b0;
    case (st_q)
      ST_START: begin
        src_d = 1'b1;
        if (sync2_q.above_on && !lat_q) begin
          src_d = 1'b0;
          ss_restart = 1'b1;
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fault_now) begin
          hic_d = HICCUP_ZERO;
          st_d = ST_DECAY;
        end
      end
      ST_DECAY: begin
        if (sync2_q.below_latch) begin
          src_d = 1'b1;
          st_d = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        src_d = 1'b1;
        if (sync2_q.above_on) begin
          src_d = 1'b0;
          if (hic_q == HICCUP_CYCLES - 1'b1) begin
            hic_d = HICCUP_ZERO;
            if (lat_q) begin
              st_d = ST_DECAY;
            end else begin
              ss_restart = 1'b1;
              st_d = ST_RUN;
            end
          end else begin
            hic_d = hic_q + 1'b1;
            st_d = ST_DECAY;
          end
        end
      end
      default: begin
        st_d = ST_START;
      end
    endcase
    run_d = (st_d == ST_RUN);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= ST_START;
      hic_q <= HICCUP_ZERO;
      src_q <= 1'b1;
      run_q <= 1'b0;
    end else begin
      st_q <= st_d;
      hic_q <= hic_d;
      src_q <= src_d;
      run_q <= run_d;
    end
  end

  // compensation ramp, restarted by the switching clock
  logic [7:0] rdiv_q, rdiv_d;
  logic [RAMP_W-1:0] ramp_q, ramp_d;

  always_comb begin
    rdiv_d = rdiv_q;
    ramp_d = ramp_q;
    if (cycle_start) begin
      rdiv_d = '0;
      ramp_d = RAMP_ZERO;
    end else if (ramp_q < RAMP_SWING_UA) begin
      if (rdiv_q == RAMP_STEP_LAST) begin
        rdiv_d = '0;
        ramp_d = ramp_q + 1'b1;
      end else begin
        rdiv_d = rdiv_q + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdiv_q <= '0;
      ramp_q <= RAMP_ZERO;
    end else begin
      rdiv_q <= rdiv_d;
      ramp_q <= ramp_d;
    end
  end

  // gate drive latch
  logic [RAMP_W-1:0] ramp_eff;
  logic [SUM_W-1:0] sense_sum;
  logic [DUTY_W-1:0] duty_pos;
  logic [DUTY_W-1:0] duty_lim;
  logic cs_trip;
  logic max_duty;
  logic gate_q, gate_d;

  always_comb begin
    // ramp is zero at the cycle start, the register only catches up an edge later
    ramp_eff = cycle_start ? RAMP_ZERO : ramp_q;
    sense_sum = SUM_W'(cs_level) + SUM_W'(ramp_eff * RAMP_KOHM);
    cs_trip = (sense_sum >= SUM_W'(mod_q));
    duty_pos = DUTY_W'(pos) * DUTY_W'(PCT_FULL);
    duty_lim = DUTY_W'(period) * DUTY_W'(MAX_DUTY_PCT);
    max_duty = (duty_pos >= duty_lim);
    gate_d = gate_q;
    if (cycle_start) gate_d = 1'b1;
    if (cs_trip || max_duty) gate_d = 1'b0;
    if (!run_q || fault_now) gate_d = 1'b0;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) gate_q <= 1'b0;
    else gate_q <= gate_d;
  end

  assign gate_drive = gate_q;
  assign startup_source_on = src_q;
  assign ramp_current = ramp_q;
  assign modulation_level = mod_q;
  assign status = '{gate: gate_q, startup_on: src_q, error: err_q, latched: lat_q, running: run_q};
endmodule // fpfh_core

// *** tb/fpfh_supply_model.sv ***
`timescale 1ns/10ps
module fpfh_supply_model import fpfh_pkg::*; (
  input wire logic mclk,
  input wire logic gate_drive,
  input wire logic startup_source_on,
  input wire logic running,
  input wire logic aux_ok,
  input wire logic bulk_ok,
  input wire logic fb_open,
  input wire logic latch_high,
  output fpfh_cmp_t cmp,
  output logic [LVL_W-1:0] cs_level
);
  logic [15:0] vcc = 16'h0000;
  initial cs_level = LVL_ZERO;
  // supply charges from the source, is held by the aux winding while switching, else decays
  always @(posedge mclk) begin
    if (startup_source_on && bulk_ok)
      vcc <= vcc + 16'h0064;
    else if (!(running && aux_ok) && vcc > 16'h0032)
      vcc <= vcc - 16'h0032;
    cs_level <= gate_drive ? cs_level + 12'h014 : LVL_ZERO;
  end
  // supply level and the fb_open and latch_high pins reach the block only as comparator bits; cs_level goes as a level
  assign cmp = '{below_off: vcc < 16'h238c, below_latch: vcc < 16'h16a8, above_on: vcc > 16'h3138,
                 below_reset: vcc < 16'h0fa0, fb_open: fb_open, latch_high: latch_high};
endmodule // fpfh_supply_model

// *** tb/fpfh_core_chk.sv ***
`timescale 1ns/10ps
module fpfh_core_chk import fpfh_pkg::*; #(
  parameter int NOM_CYC = NOM_PERIOD_CYC,
  parameter int RAMP_KOHM = RAMP_RES_KOHM
) (
  input wire logic mclk,
  input wire logic rst,
  input wire fpfh_cmp_t cmp_async,
  input wire logic [LVL_W-1:0] feedback_level,
  input wire logic [LVL_W-1:0] cs_level,
  input wire logic gate_drive,
  input wire logic startup_source_on,
  input wire logic [RAMP_W-1:0] ramp_current,
  input wire logic [LVL_W-1:0] modulation_level,
  input wire fpfh_status_t status
);
  localparam int HI_MAX = (NOM_CYC + NOM_CYC * 75 / 1000) * 80 / 100 + 3;
  int hi_q;
  int hi_d;
  // length of the current gate pulse
  always_comb hi_d = gate_drive ? hi_q + 1 : 0;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      hi_q <= 0;
    else
      hi_q <= hi_d;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_gate_run: assert property (gate_drive |-> status.running)
    else $error("gate high while stopped");
  a_mod_clamp: assert property (modulation_level <= LVL_FULL_MV)
    else $error("modulation above clamp");
  a_mod_min: assert property (3 * int'(modulation_level) <= int'($past(feedback_level)))
    else $error("modulation above feedback third");
  a_pulse_trip: assert property (gate_drive && int'(cs_level) + int'(ramp_current) * RAMP_KOHM
    >= int'(modulation_level) |=> !gate_drive)
    else $error("pulse not ended at trip");
  a_duty_max: assert property (hi_q <= HI_MAX)
    else $error("pulse beyond maximum duty");
  a_ramp_restart: assert property ($rose(gate_drive) |-> ramp_current == RAMP_ZERO)
    else $error("ramp not restarted");
  a_supply_undervoltage_lockout_stop: assert property (status.running && cmp_async.below_off
    |-> ##[1:4] (!status.running && !gate_drive))
    else $error("no stop on low supply");
  a_err_set: assert property (status.running && feedback_level >= 12'hbbb
    |=> status.error || !status.running)
    else $error("overload flag missing");
  a_latch_stop: assert property (status.latched |=> !status.running)
    else $error("running while latched");
  a_latch_free: assert property ($fell(status.latched) |-> $past(cmp_async.below_reset, 2)
    || $past(cmp_async.below_reset, 3) || $past(cmp_async.below_reset, 4))
    else $error("latch released early");
  a_hic_charge: assert property ($rose(startup_source_on) |-> $past(cmp_async.below_latch, 2)
    || $past(cmp_async.below_latch, 3) || $past(cmp_async.below_latch, 4))
    else $error("source on above latch level");
  c_run: cover property ($rose(status.running));
  c_err: cover property ($rose(status.error));
  c_latch: cover property ($rose(status.latched));
endmodule // fpfh_core_chk
bind fpfh_core fpfh_core_chk #(.NOM_CYC(NOM_CYC), .RAMP_KOHM(RAMP_KOHM)) fpfh_core_chk_inst (
  .mclk(mclk), .rst(rst), .cmp_async(cmp_async), .feedback_level(feedback_level), .cs_level(cs_level),
  .gate_drive(gate_drive), .startup_source_on(startup_source_on), .ramp_current(ramp_current),
  .modulation_level(modulation_level), .status(status));

// *** tb/fpfh_core_bench.sv ***
`timescale 1ns/10ps
module fpfh_core_bench import fpfh_pkg::*; ;
  localparam int SSC = 2000;
  localparam int FLT = 500;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic aux_ok = 1'b1;
  logic bulk_ok = 1'b1;
  logic fb_open = 1'b0;
  logic latch_high = 1'b0;
  logic [LVL_W-1:0] fb = 12'h05dc;
  fpfh_cmp_t cmp;
  logic [LVL_W-1:0] cs;
  logic gate;
  logic src;
  logic [RAMP_W-1:0] ramp;
  logic [LVL_W-1:0] mod;
  fpfh_status_t st;
  int fails = 0;
  int n_tests = 0;
  int k;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: got %h exp %h", $time, a, b); end end
`define WT(c, n) begin for (k = 0; k < (n) && !(c); k++) @(negedge mclk); `CHK((c), 1'b1) \
  if ((c) !== 1'b1) wrap_up; end
  initial forever #20 mclk = ~mclk;
  fpfh_core #(.NOM_CYC(50), .SS_CYCLES(SSC), .FAULT_CYCLES(FLT), .JIT_CYCLES(2000), .RAMP_KOHM(5))
  fpfh_core_inst (.mclk(mclk), .rst(rst), .cmp_async(cmp), .feedback_level(fb), .cs_level(cs),
    .gate_drive(gate), .startup_source_on(src), .ramp_current(ramp), .modulation_level(mod), .status(st));
  fpfh_supply_model fpfh_supply_model_inst (.mclk(mclk), .gate_drive(gate), .startup_source_on(src),
    .running(st.running), .aux_ok(aux_ok), .bulk_ok(bulk_ok), .fb_open(fb_open),
    .latch_high(latch_high), .cmp(cmp), .cs_level(cs));
  task automatic go(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic t_start;
    `WT(st.running, 400)
    `CHK(src, 1'b0)
    `WT(gate, 60)
    `CHK(ramp, RAMP_ZERO)
    go(SSC / 4);
    `CHK(mod > 12'h0c8 && mod < 12'h12c, 1'b1)
    go(SSC);
    `CHK(mod, 12'h1f4)
    @(posedge mclk) fb <= 12'h0fa0;
    go(4);
    `CHK(mod, LVL_FULL_MV)
    `CHK(st.error, 1'b1)
    @(posedge mclk) fb <= 12'h05dc;
    go(4);
    `CHK({st.error, st.running}, 2'b01)
  endtask
  task automatic t_open;
    @(posedge mclk) fb_open <= 1'b1;
    go(FLT - 20);
    `CHK(st.running, 1'b1)
    `WT(!st.running, 60)
    @(posedge mclk) fb_open <= 1'b0;
    `WT(src, 400)
    `WT(!src, 400)
    `CHK(st.running, 1'b0)
    `WT(src, 400)
    `WT(st.running, 400)
    go(2);
    `CHK(mod < 12'h00a, 1'b1)
  endtask
  task automatic t_supply_undervoltage_lockout;
    go(SSC);
    @(posedge mclk) aux_ok <= 1'b0;
    `WT(!st.running, 120)
    `CHK(gate, 1'b0)
    @(posedge mclk) aux_ok <= 1'b1;
    `WT(st.running, 1200)
  endtask
  task automatic t_latch;
    @(posedge mclk) latch_high <= 1'b1;
    go(300);
    `CHK(st.latched, 1'b0)
    `WT(st.latched, 40)
    @(posedge mclk) latch_high <= 1'b0;
    go(1500);
    `CHK({st.latched, st.running, gate}, 3'b100)
    @(posedge mclk) bulk_ok <= 1'b0;
    `WT(!st.latched, 400)
    @(posedge mclk) bulk_ok <= 1'b1;
    `WT(st.running, 1500)
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_start;
    t_open;
    t_supply_undervoltage_lockout;
    t_latch;
    wrap_up;
  end
endmodule // fpfh_core_bench
